// ---- verilog/bmp_pkg.sv ----
// Package for the blit mask, pattern and configuration block.
// Assumes one core clock; bmp_core and the bench import it whole, bmp_fifo does not.
package bmp_pkg;
   // Register offsets, low 23 address bits (both address mirrors decode)
   localparam logic [22:0] CTRL_OFF = 23'h40_0010;
   localparam logic [22:0] PAT_OFF = 23'h40_0014;
   localparam logic [22:0] DATA_OFF = 23'h40_0100;
   // Field positions in blit_operation_control
   localparam int B_BUSY = 31;
   localparam int B_SOLID = 19;
   localparam int B_PATDEP = 18;
   localparam int B_PATMASK = 17;
   localparam int B_CMP = 14;
   localparam int B_SRCMASK = 13;
   localparam int B_SRCDEP = 12;
   localparam int B_SRCSEL = 10;
   localparam int B_START = 8;
   // Reset values and writable bits
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PAT_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h007F_F7FF;
   localparam logic [31:0] PAT_WMASK = 32'h007F_FFF8;
   // FIFO depth, pattern geometry and fetch counts
   localparam int FIFO_DEPTH = 8;
   localparam logic [2:0] PAT_LAST_ROW = 3'h7;
   localparam logic [1:0] QW_LAST_8 = 2'h0;
   localparam logic [1:0] QW_LAST_16 = 2'h1;
   localparam logic [1:0] QW_LAST_24 = 2'h2;
   localparam logic [2:0] STRIDE_8 = 3'h1;
   localparam logic [2:0] STRIDE_16 = 3'h2;
   localparam logic [2:0] STRIDE_24 = 3'h4;
   // Engine colour depth codes
   localparam logic [1:0] BPP8 = 2'h0;
   localparam logic [1:0] BPP16 = 2'h1;
   localparam logic [1:0] BPP24 = 2'h2;

   typedef enum logic [1:0] {
      CORNER_UL = 2'b00,
      CORNER_UR = 2'b01,
      CORNER_LL = 2'b10,
      CORNER_LR = 2'b11
   } bmp_corner_t;

   typedef enum logic {
      PF_IDLE = 1'b0,
      PF_RUN = 1'b1
   } bmp_pf_state_t;

   typedef struct packed {
      logic we;
      logic re;
      logic [23:0] addr;
      logic [3:0] strb;
      logic [31:0] wdata;
   } bmp_reg_req_t;

   typedef struct packed {
      logic [23:0] pat;
      logic [23:0] fb_src;
      logic [23:0] dst;
      logic [23:0] bg;
      logic pat_bit;
      logic src_bit;
   } bmp_pix_t;

   typedef struct packed {
      logic wr;
      logic [23:0] color;
   } bmp_res_t;
endpackage

// ---- verilog/bmp_fifo.sv ----
// Host data FIFO with registered full and empty flags.
// Assumes one clock, synchronous active-low reset and a freezing enable.
`timescale 1ns/1ns
module bmp_fifo #(
   parameter int W = 32,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic full_q;
   logic empty_q;
   logic push;
   logic pop;

   assign push = in_valid && !full_q;
   assign pop = out_ready && !empty_q;
   assign out_valid = !empty_q;
   assign out_data = mem_q[rp_q];

   // Occupancy; flags registered so ports stay flop-driven
   always_comb
   begin
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         full_q <= 1'b0;
         in_ready <= 1'b1;
         empty_q <= 1'b1;
         wp_q <= '0;
         rp_q <= '0;
      end
      else if (ce)
      begin
         cnt_q <= cnt_d;
         full_q <= (cnt_d == (AW+1)'(D));
         in_ready <= (cnt_d != (AW+1)'(D)); // Own flop, no inverter on the port
         empty_q <= (cnt_d == '0);
         if (push)
            wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
         if (pop)
            rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge clk)
   begin
      if (ce && push)
         mem_q[wp_q] <= in_data;
   end

   chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
      cnt_q <= (AW+1)'(D))
      else $error("fifo count above depth");
endmodule // bmp_fifo

// ---- verilog/bmp_core.sv ----
// Blit mask, pattern and configuration logic: control and pattern
// address registers, host data port, per-pixel raster op and write
// masks, pattern fetch address sequencer.
// Assumes all inputs come from logic on CORE_CLK; the engine datapath
// holds PIX_REQ until PIX_ACK and keeps PAT_RD_READY as a handshake.
// Operation
// - Mono pattern zero bit suppresses pixel write
// - Compare field bit zero disables compare masking
// - Compare background with result or destination
// - Mono source zero bit suppresses pixel write
// - Source depth bit selects colour or mono
// - Control bit 11 always reads zero
// - Source select zero fetches from frame buffer
// - Source select one takes host data port writes
// - Starting point field picks the corner
// - Starting point resets to upper left
// - Eight-bit code picks three-operand raster operation
// - Pattern address held in bits 22 to 3
// - Pattern is always eight by eight pixels
// - 24-bit rows fetch 24 of 32 bytes
// - Pattern address reserved bits read zero
// - Pattern depth bit selects colour or mono
`timescale 1ns/1ns
module bmp_core #(
   parameter int FIFO_W = 32,
   parameter int FIFO_D = bmp_pkg::FIFO_DEPTH
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire bmp_pkg::bmp_reg_req_t REG_REQ,
   output logic [31:0] REG_RDATA,
   output logic REG_RACK,
   output logic HOST_DATA_READY,
   input wire logic ENGINE_BUSY,
   input wire logic [1:0] ENGINE_BPP,
   input wire logic PIX_REQ,
   input wire bmp_pkg::bmp_pix_t PIX_IN,
   output logic PIX_ACK,
   output bmp_pkg::bmp_res_t PIX_RES,
   input wire logic PAT_FETCH_START,
   output logic PAT_RD_VALID,
   input wire logic PAT_RD_READY,
   output logic [22:0] PAT_RD_ADDR,
   output logic PAT_FETCH_DONE,
   output logic SRC_FROM_FB,
   output logic X_DECREMENT,
   output logic Y_DECREMENT
);
   import bmp_pkg::*;

   logic [31:0] ctrl_q;
   logic [31:0] pat_q;
   logic [31:0] wmask;
   logic ctrl_hit;
   logic pat_hit;
   logic data_hit;
   logic pat_mono;
   logic src_mono;
   logic src_host;
   logic [2:0] cmp_sel;
   logic [7:0] rop;
   logic fifo_in_ready;
   logic fifo_ov;
   logic [FIFO_W-1:0] fifo_data;
   logic accept;
   logic [23:0] src_color;
   logic src_bit;
   logic [23:0] rop_res;
   logic [23:0] cmp_color;
   logic [23:0] depth_mask;
   logic cmp_eq;
   logic pat_ok;
   logic src_ok;
   logic cmp_ok;
   bmp_pf_state_t pf_q;
   logic [2:0] row_q;
   logic [1:0] qw_q;
   logic [1:0] qw_last;
   logic [2:0] stride;
   logic [2:0] row_d;
   logic [1:0] qw_d;
   logic fetch_last;

   // Address decode; bit 23 ignored so both mirrors answer
   assign ctrl_hit = (REG_REQ.addr[22:0] == CTRL_OFF);
   assign pat_hit = (REG_REQ.addr[22:0] == PAT_OFF);
   assign data_hit = (REG_REQ.addr[22:0] == DATA_OFF);
   // Word or doubleword writes: each strobe pair covers one half
   assign wmask = {{16{REG_REQ.strb[3]}}, {16{REG_REQ.strb[1]}}};

   // Control register; reserved and status bits never stored
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         ctrl_q <= CTRL_RST;
      else if (CE && REG_REQ.we && ctrl_hit)
         ctrl_q <= (ctrl_q & ~(wmask & CTRL_WMASK)) | (REG_REQ.wdata & wmask & CTRL_WMASK);
   end

   // Pattern address register, bits 22:3 only
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         pat_q <= PAT_RST;
      else if (CE && REG_REQ.we && pat_hit)
         pat_q <= (pat_q & ~(wmask & PAT_WMASK)) | (REG_REQ.wdata & wmask & PAT_WMASK);
   end

   // Read port: one cycle after the request; unmapped reads give zero
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         REG_RDATA <= 32'h0000_0000;
         REG_RACK <= 1'b0;
      end
      else if (CE)
      begin
         REG_RACK <= REG_REQ.re;
         if (REG_REQ.re && ctrl_hit)
            REG_RDATA <= {ENGINE_BUSY, ctrl_q[30:0]};
         else if (REG_REQ.re && pat_hit)
            REG_RDATA <= pat_q;
         else
            REG_RDATA <= 32'h0000_0000;
      end
   end

   assign pat_mono = ctrl_q[B_PATDEP];
   assign src_mono = ctrl_q[B_SRCDEP];
   assign src_host = ctrl_q[B_SRCSEL];
   assign cmp_sel = ctrl_q[B_CMP+2:B_CMP];
   assign rop = ctrl_q[7:0];

   // Host data port feeds the FIFO only while host source is selected
   bmp_fifo #(
      .W(FIFO_W),
      .D(FIFO_D)
   ) u_fifo (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .ce(CE),
      .in_valid(REG_REQ.we && data_hit && src_host),
      .in_ready(fifo_in_ready),
      .in_data(REG_REQ.wdata),
      .out_valid(fifo_ov),
      .out_ready(accept && src_host),
      .out_data(fifo_data)
   );

   // Ready is the FIFO's own registered not-full flop, not its full flag
   assign HOST_DATA_READY = fifo_in_ready;

   // A pixel waits for host data, so a slow host stalls the engine
   assign accept = PIX_REQ && !PIX_ACK && (!src_host || fifo_ov);

   // Source from frame buffer or host port
   assign src_color = src_host ? fifo_data[23:0] : PIX_IN.fb_src;
   assign src_bit = src_host ? fifo_data[0] : PIX_IN.src_bit;

   // Three-operand raster op per bit: index is {pattern, source, dest}
   for (genvar i = 0; i < 24; i++)
   begin : g_rop
      assign rop_res[i] = rop[{PIX_IN.pat[i], src_color[i], PIX_IN.dst[i]}];
   end

   // Compare only the bytes that make up a pixel at this depth
   always_comb
   begin
      unique case (ENGINE_BPP)
         BPP16: depth_mask = 24'h00_FFFF;
         BPP24: depth_mask = 24'hFF_FFFF;
         default: depth_mask = 24'h00_00FF;
      endcase
   end

   assign cmp_color = cmp_sel[1] ? PIX_IN.dst : rop_res;
   assign cmp_eq = ((cmp_color ^ PIX_IN.bg) & depth_mask) == 24'h00_0000;
   assign cmp_ok = !cmp_sel[0] || (cmp_sel[2] ? cmp_eq : !cmp_eq);
   assign pat_ok = !(pat_mono && ctrl_q[B_PATMASK]) || PIX_IN.pat_bit;
   assign src_ok = !(src_mono && ctrl_q[B_SRCMASK]) || src_bit;

   // Result stage; ack is a one-cycle pulse per accepted pixel
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         PIX_ACK <= 1'b0;
         PIX_RES <= '0;
      end
      else if (CE)
      begin
         PIX_ACK <= accept;
         if (accept)
         begin
            PIX_RES.wr <= pat_ok && src_ok && cmp_ok;
            PIX_RES.color <= rop_res;
         end
      end
   end

   // Corner and source routing to the address walkers
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         SRC_FROM_FB <= 1'b1;
         X_DECREMENT <= 1'b0;
         Y_DECREMENT <= 1'b0;
      end
      else if (CE)
      begin
         SRC_FROM_FB <= !src_host;
         X_DECREMENT <= ctrl_q[B_START];
         Y_DECREMENT <= ctrl_q[B_START+1];
      end
   end

   // Quadwords per row and row stride by depth; 24-bit rows skip padding
   always_comb
   begin
      unique case (ENGINE_BPP)
         BPP16:
         begin
            qw_last = QW_LAST_16;
            stride = STRIDE_16;
         end
         BPP24:
         begin
            qw_last = QW_LAST_24;
            stride = STRIDE_24;
         end
         default:
         begin
            qw_last = QW_LAST_8;
            stride = STRIDE_8;
         end
      endcase
   end

   // Mono pattern is one quadword; colour walks eight rows
   assign fetch_last = pat_mono || (row_q == PAT_LAST_ROW && qw_q == qw_last);
   assign qw_d = (qw_q == qw_last) ? 2'h0 : qw_q + 2'h1;
   assign row_d = (qw_q == qw_last) ? row_q + 3'h1 : row_q;

   // Pattern fetch sequencer
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         pf_q <= PF_IDLE;
         row_q <= 3'h0;
         qw_q <= 2'h0;
         PAT_RD_VALID <= 1'b0;
         PAT_RD_ADDR <= 23'h00_0000;
         PAT_FETCH_DONE <= 1'b0;
      end
      else if (CE)
      begin
         PAT_FETCH_DONE <= 1'b0;
         unique case (pf_q)
            PF_IDLE:
            begin
               row_q <= 3'h0;
               qw_q <= 2'h0;
               // Solid pattern needs no pattern data at all
               if (PAT_FETCH_START && !(pat_mono && ctrl_q[B_SOLID]))
               begin
                  pf_q <= PF_RUN;
                  PAT_RD_VALID <= 1'b1;
                  PAT_RD_ADDR <= {pat_q[22:3], 3'h0};
               end
               else if (PAT_FETCH_START)
                  PAT_FETCH_DONE <= 1'b1;
            end
            PF_RUN:
            begin
               if (PAT_RD_READY)
               begin
                  if (fetch_last)
                  begin
                     pf_q <= PF_IDLE;
                     PAT_RD_VALID <= 1'b0;
                     PAT_FETCH_DONE <= 1'b1;
                  end
                  else
                  begin
                     row_q <= row_d;
                     qw_q <= qw_d;
                     PAT_RD_ADDR <= {pat_q[22:3], 3'h0} + {15'h0000,
                        5'(row_d * stride) + {3'h0, qw_d}, 3'h0};
                  end
               end
            end
         endcase
      end
   end

   chk_pat_mask_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && accept && pat_mono && ctrl_q[B_PATMASK] && !PIX_IN.pat_bit |=> !PIX_RES.wr)
      else $error("masked pattern pixel written");

   chk_src_mask_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && accept && src_mono && ctrl_q[B_SRCMASK] && !src_bit |=> !PIX_RES.wr)
      else $error("masked source pixel written");

   chk_cmp_off_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && accept && !cmp_sel[0] && pat_ok && src_ok |=> PIX_RES.wr)
      else $error("pixel dropped with compare off");

   chk_rop_srccopy: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && accept && rop == 8'hCC && !src_host |=> PIX_RES.color == $past(PIX_IN.fb_src))
      else $error("source copy code gave wrong colour");

   chk_host_stall: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && PIX_REQ && !PIX_ACK && src_host && !fifo_ov |=> !PIX_ACK)
      else $error("pixel taken without host data");

   chk_ctrl_bit11: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && REG_REQ.re && ctrl_hit |=> REG_RACK && !REG_RDATA[11])
      else $error("reserved control bit read nonzero");

   chk_pat_reserved: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && REG_REQ.re && pat_hit |=> REG_RDATA[31:23] == 9'h000 && REG_RDATA[2:0] == 3'h0)
      else $error("pattern reserved bits read nonzero");

   chk_reset_corner: assert property (@(posedge CORE_CLK)
      !RST_N |=> ctrl_q[B_START+1:B_START] == CORNER_UL)
      else $error("corner not upper left after reset");

   chk_fetch_24_pad: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PAT_RD_VALID && !pat_mono && ENGINE_BPP == BPP24 |->
         qw_q <= QW_LAST_24 && PAT_RD_ADDR[4:3] != 2'h3)
      else $error("padding quadword fetched");
endmodule // bmp_core

// ---- testbench/bmp_pat_mem.sv ----
// Pattern memory model answering quadword reads from the fetch sequencer.
// Assumes the bench seeds $urandom once; same clock as the core.
`timescale 1ns/1ns
module bmp_pat_mem (
   input wire logic clk,
   input wire logic start,
   input wire logic valid,
   input wire logic [22:0] addr,
   output logic ready
);
   int n = 0;
   logic [22:0] a [0:31];
   initial ready = 1'b0;
   // Log accepted addresses, restarting the log at each fetch start
   always @(posedge clk)
   begin
      if (start)
         n <= 0;
      else if (valid && ready)
      begin
         a[n[4:0]] <= addr;
         n <= n + 1;
      end
      // Stall about a third of the time so the address must hold
      ready <= #1 ($urandom_range(2) != 0);
   end
endmodule // bmp_pat_mem

// ---- testbench/tb_top.sv ----
// Self-checking bench: registers, host data FIFO, pixel masks, fetch.
// Assumes bmp_pkg and bmp_pat_mem; random stimulus from a fixed seed.
`timescale 1ns/1ns
module tb_top;
   import bmp_pkg::*;
   localparam logic [23:0] AC = {1'b0, CTRL_OFF};
   localparam logic [23:0] AP = {1'b0, PAT_OFF};
   localparam logic [23:0] AD = {1'b0, DATA_OFF};
   logic clk, rst_n, busy, preq, pstart, rack, hrdy, pack, prv, prr, pdone;
   logic sfb, xd, yd;
   logic [1:0] bpp;
   logic [22:0] pra;
   logic [31:0] rdata;
   bmp_reg_req_t rq;
   bmp_pix_t pin;
   bmp_res_t res;
   int err_count, check_count;

   bmp_core uut (.CORE_CLK(clk), .RST_N(rst_n), .CE(1'b1), .REG_REQ(rq),
      .REG_RDATA(rdata), .REG_RACK(rack), .HOST_DATA_READY(hrdy),
      .ENGINE_BUSY(busy), .ENGINE_BPP(bpp), .PIX_REQ(preq), .PIX_IN(pin),
      .PIX_ACK(pack), .PIX_RES(res), .PAT_FETCH_START(pstart),
      .PAT_RD_VALID(prv), .PAT_RD_READY(prr), .PAT_RD_ADDR(pra),
      .PAT_FETCH_DONE(pdone), .SRC_FROM_FB(sfb), .X_DECREMENT(xd),
      .Y_DECREMENT(yd));
   bmp_pat_mem pm (.clk(clk), .start(pstart), .valid(prv), .addr(pra), .ready(prr));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic fail(input string m);
      err_count++;
      $display("FAIL %0t %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp)
         fail($sformatf("%s got %h exp %h", m, got, exp));
   endtask
   // Bus cycles: one edge for the request, one edge before the next
   task automatic wr(input logic [23:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      #1 rq = '{1'b1, 1'b0, a, s, d};
      @(posedge clk);
      #1 rq = '0;
   endtask
   task automatic rd(input logic [23:0] a, output logic [31:0] d);
      @(posedge clk);
      #1 rq = '{1'b0, 1'b1, a, 4'hA, 32'h0};
      @(posedge clk);
      #1 rq = '0;
      chk(rack, 1, "read ack");
      d = rdata;
   endtask
   // Request stays up through the edge that sees the ack
   task automatic wait_ack(output bmp_res_t r);
      int k;
      k = 0;
      while (pack !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= 20)
         fail("pixel ack missing");
      r = res;
      @(posedge clk);
      #1 preq = 1'b0;
   endtask
   task automatic pix(input bmp_pix_t p, output bmp_res_t r);
      @(posedge clk);
      #1 pin = p;
      preq = 1'b1;
      wait_ack(r);
   endtask
   // Raster op per bit, then every enabled mask must allow the write
   function automatic bmp_res_t exp_pix(input logic [31:0] c, input bmp_pix_t p,
      input logic [1:0] b);
      logic [23:0] r, m, a;
      logic ok;
      for (int i = 0; i < 24; i++)
         r[i] = c[{p.pat[i], p.fb_src[i], p.dst[i]}];
      m = (b == BPP16) ? 24'h00FFFF : (b == BPP24) ? 24'hFFFFFF : 24'h0000FF;
      a = c[B_CMP+1] ? p.dst : r;
      ok = !c[B_CMP] || (c[B_CMP+2] == ((a & m) == (p.bg & m)));
      ok = ok && !(c[B_PATMASK] && c[B_PATDEP] && !p.pat_bit);
      ok = ok && !(c[B_SRCMASK] && c[B_SRCDEP] && !p.src_bit);
      return '{ok, r};
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog sized well past the expected few thousand cycles
   initial
   begin
      #40000;
      fail("watchdog");
      summarize();
   end

   initial
   begin
      logic [31:0] d, x, c, wm, ctl, pat;
      logic [31:0] w [0:7];
      logic [22:0] base;
      bmp_pix_t p;
      bmp_res_t r, e;
      int b, n;
      {rst_n, busy, preq, pstart, bpp} = '0;
      rq = '0;
      pin = '0;
      err_count = 0;
      check_count = 0;
      d = $urandom(32'h5D20E88C);
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      chk({sfb, yd, xd}, 3'h4, "reset outputs");
      rd({1'b1, CTRL_OFF}, x);
      chk(x, CTRL_RST, "ctrl reset");
      rd(AP, x);
      chk(x, PAT_RST, "pat reset");
      ctl = CTRL_RST;
      pat = PAT_RST;
      // Random half-word writes, reserved bits must stay zero
      repeat (24)
      begin
         d = $urandom;
         c = $urandom;
         wm = {{16{c[3]}}, {16{c[1]}}};
         busy = c[5];
         wr(AC, d, c[3:0]);
         ctl = (ctl & ~(wm & CTRL_WMASK)) | (d & wm & CTRL_WMASK);
         rd(AC, x);
         chk(x, {busy, ctl[30:0]}, "ctrl read");
         wr(AP, ~d, c[3:0]);
         pat = (pat & ~(wm & PAT_WMASK)) | (~d & wm & PAT_WMASK);
         rd(AP, x);
         chk(x, pat, "pat read");
      end
      rd(24'h40_0040, x);
      chk(x, 32'h0, "unmapped read");
      busy = 1'b0;
      $display("test registers done");
      // Every raster code once, random masks, corners and depths
      for (int i = 0; i < 256; i++)
      begin
         c = ($urandom & 32'h0007_F300) | i;
         if (c[12] || c[18])
            c[15] = 1'b1;
         if (c[12])
            c[8] = 1'b0;
         b = $urandom_range(3);
         p = 98'({$urandom, $urandom, $urandom, $urandom});
         e = exp_pix(c, p, b[1:0]);
         case ($urandom_range(2))
            0: p.bg = p.dst;
            1: p.bg = e.color;
            default: ;
         endcase
         e = exp_pix(c, p, b[1:0]);
         wr(AC, c, 4'hA);
         bpp = b[1:0];
         pix(p, r);
         chk({sfb, yd, xd}, {1'b1, c[9:8]}, "corner");
         chk(r.wr, e.wr, "write enable");
         if (!c[12] && !c[18])
            chk(r.color, e.color, "rop colour");
      end
      $display("test pixels done");
      // Host port: dropped while frame-buffer source, fill, drain, stall
      wr(AD, 32'h0012_3457, 4'hA);
      wr(AC, 32'h0000_04CC, 4'hA);
      // Routing flop follows the control register one edge later
      @(posedge clk);
      #1 chk(sfb, 0, "host source");
      for (int k = 0; k < 8; k++)
      begin
         w[k] = $urandom;
         wr(AD, w[k], 4'hA);
         if (k < 7)
            chk(hrdy, 1, "fifo room");
      end
      @(posedge clk);
      #1 chk(hrdy, 0, "fifo full");
      wr(AD, 32'h00FF_FFFF, 4'hA);
      for (int k = 0; k < 8; k++)
      begin
         p = 98'({$urandom, $urandom, $urandom, $urandom});
         pix(p, r);
         chk(r.color, w[k][23:0], "host word");
         chk(r.wr, 1, "host write");
      end
      chk(hrdy, 1, "fifo drained");
      wr(AC, 32'h0000_34CC, 4'hA);
      pin = p;
      preq = 1'b1;
      repeat (6)
      begin
         @(posedge clk);
         #1 chk(pack, 0, "stall on empty");
      end
      wr(AD, 32'h00AB_CDE0, 4'hA);
      wait_ack(r);
      chk(r.wr, 0, "mono host mask");
      $display("test host data done");
      // Fetch: mono, 8, 16, 24 bpp colour, then solid mono
      for (int m = 0; m < 5; m++)
      begin
         b = (m == 0 || m == 4) ? 0 : m - 1;
         base = 23'($urandom);
         base = base & ~((m == 0 || m == 4) ? 23'h7 : (23'h40 << b) - 23'h1);
         bpp = b[1:0];
         wr(AP, {9'h0, base}, 4'hA);
         wr(AC, {12'h0, m == 4, m == 0 || m == 4, 18'h0}, 4'hA);
         @(posedge clk);
         #1 pstart = 1'b1;
         @(posedge clk);
         #1 pstart = 1'b0;
         n = 0;
         while (pdone !== 1'b1 && n < 200)
         begin
            @(posedge clk);
            #1 n++;
         end
         chk(n < 200, 1, "fetch done");
         n = (m == 4) ? 0 : (m == 0) ? 1 : 8 * (b + 1);
         chk(pm.n, n, "read count");
         for (int k = 0; k < n; k++)
            chk(pm.a[k], base + (k / (b + 1)) * (8 << b) + (k % (b + 1)) * 8, "qw addr");
      end
      $display("test fetch done");
      summarize();
   end
endmodule // tb_top
